// *** inc/mdc_pkg.sv ***
// Register map, field positions and reset values for the motion detect configuration bank.
// Assumes a byte-wide register port driven by the serial front end (I2C or SPI).
package mdc_pkg;
   // Register offsets
   localparam logic [7:0] MDC_ADDR_ZTRIM_LO = 8'h14;
   localparam logic [7:0] MDC_ADDR_ZTRIM_HI = 8'h15;
   localparam logic [7:0] MDC_ADDR_MODE = 8'h16;
   localparam logic [7:0] MDC_ADDR_LATCH_CLR = 8'h17;
   localparam logic [7:0] MDC_ADDR_CTRL_ONE = 8'h18;
   localparam logic [7:0] MDC_ADDR_CTRL_TWO = 8'h19;
   localparam logic [7:0] MDC_ADDR_LVL_TH = 8'h1a;
   localparam logic [7:0] MDC_ADDR_PLS_TH = 8'h1b;
   localparam logic [7:0] MDC_ADDR_PLS_DUR = 8'h1c;
   // Implemented bits per register
   localparam logic [7:0] MDC_MASK_ZTRIM_HI = 8'h07;
   localparam logic [7:0] MDC_MASK_MODE = 8'h7f;
   localparam logic [7:0] MDC_MASK_LATCH_CLR = 8'h03;
   localparam logic [7:0] MDC_MASK_CTRL_TWO = 8'h07;
   localparam logic [7:0] MDC_RESET_VAL = 8'h00;
   // Mode control fields
   localparam int MDC_MODE_LSB = 0;
   localparam int MDC_GRANGE_LSB = 2;
   localparam int MDC_SELF_TEST_BIT = 4;
   localparam int MDC_THREE_WIRE_BIT = 5;
   localparam int MDC_READY_DIS_BIT = 6;
   // Latch clear fields
   localparam int MDC_CLR_FIRST_BIT = 0;
   localparam int MDC_CLR_SECOND_BIT = 1;
   // Control one fields
   localparam int MDC_PIN_SWAP_BIT = 0;
   localparam int MDC_ASSIGN_LSB = 1;
   localparam int MDC_AXIS_DIS_LSB = 3;
   localparam int MDC_TH_OPT_BIT = 6;
   localparam int MDC_BW_BIT = 7;
   // Control two fields
   localparam int MDC_LVL_POL_BIT = 0;
   localparam int MDC_PLS_POL_BIT = 1;
   localparam int MDC_DRIVE_BIT = 2;
   // Sensitivity in LSB per g for each range
   localparam logic [6:0] MDC_SENS_8G = 7'd16;
   localparam logic [6:0] MDC_SENS_2G = 7'd64;
   localparam logic [6:0] MDC_SENS_4G = 7'd32;
   // Filter bandwidth in tenths of Hz
   localparam logic [10:0] MDC_BW_LOW_DHZ = 11'd625;
   localparam logic [10:0] MDC_BW_HIGH_DHZ = 11'd1250;
   // Pulse duration step in microseconds
   localparam int MDC_PLS_STEP_US = 500;

   typedef enum logic [1:0] {
      MDC_MODE_STANDBY,
      MDC_MODE_MEASURE,
      MDC_MODE_LEVEL,
      MDC_MODE_PULSE
   } mdc_mode_t;

   typedef enum logic [1:0] {
      MDC_ASG_LVL_PLS,
      MDC_ASG_PLS_LVL,
      MDC_ASG_SGL_DBL,
      MDC_ASG_RSVD
   } mdc_assign_t;
endpackage : mdc_pkg

// *** rtl/mdc_axis_cmp.sv ***
// Per-axis threshold comparator for level and pulse detection.
// Assumes signed 8-bit axis samples already offset-corrected.
`timescale 1ns/1ps
module mdc_axis_cmp #(
   parameter int AXES = 3
) (
   // Samples and enables
   input wire logic [8*AXES-1:0] sample,
   input wire logic [AXES-1:0] axis_disable,
   // Settings
   input wire logic [7:0] threshold,
   input wire logic signed_mode,
   input wire logic neg_polarity,
   // Per-axis hits and combined result
   output logic [AXES-1:0] hit,
   output logic combined
);
   import mdc_pkg::*;

   // One comparator per axis
   genvar g;
   generate
      for (g = 0; g < AXES; g++) begin : g_axis
         logic signed [8:0] s;
         logic signed [8:0] mag;
         logic signed [8:0] th;
         assign s = {sample[8*g+7], sample[8*g +: 8]};
         // Absolute mode compares magnitude against the 7-bit limit
         assign mag = s[8] ? -s : s;
         assign th = signed_mode ? {threshold[7], threshold} : {2'b00, threshold[6:0]};
         // One continuous driver per bit keeps each hit single-sourced
         assign hit[g] = axis_disable[g] ? 1'b0 :
                         !signed_mode ? (neg_polarity ? (mag < th) : (mag >= th)) :
                         (neg_polarity ? (s <= -th) : (s >= th));
      end
   endgenerate

   // Positive polarity: any axis; negative: every enabled axis
   assign combined = neg_polarity ? ((&(hit | axis_disable)) && !(&axis_disable)) : (|hit);
endmodule : mdc_axis_cmp

// *** rtl/mdc_regs.sv ***
// Configuration register bank with detection flag logic of a three-axis accelerometer.
// Assumes the serial front end presents one-cycle byte writes and combinational-address reads.
// Detection is judged per sample; duration and double-pulse timing belong to the engine outside.
//
// Overview of operation
// (R01) Z trim low byte holds bits 7:0, weights 0.5 to 64 LSB.
// (R02) Z trim high register bits 2:0: sign, 256 LSB, 128 LSB.
// (R03) Range code 00 is 8g, 01 is 2g, 10 is 4g.
// (R04) Self-test is on exactly while mode bit 4 is one.
// (R05) Mode field: standby, measurement, level detect, pulse detect.
// (R06) SPI runs three-wire when select bit is one, else four-wire.
// (R07) Ready-pin disable bit keeps data ready off the first interrupt pin.
// (R08) Writing a latch-clear bit clears that flag and its axis flags.
// (R09) Assignment field maps level, pulse, single or double pulse to flags.
// (R10) Setting 10: second flag is single pulse unless both windows nonzero.
// (R11) Pin-swap bit exchanges which flag drives each interrupt pin.
// (R12) A set axis-disable bit removes that axis from detection.
// (R13) Threshold option picks absolute or signed level compare; pulse ignores it.
// (R14) Bandwidth bit chooses 62.5 Hz or 125 Hz filter.
// (R15) Level polarity bit: positive OR, or negative AND across axes.
// (R16) Pulse polarity bit: positive OR, or negative AND across axes.
// (R17) Drive-select bit picks standard or strong data-out drive.
// (R18) Level threshold is unsigned 7 bits or signed 8 bits by option.
// (R19) Pulse threshold is unsigned bits 6:0; host keeps bit 7 zero.
// (R20) Pulse duration counts 0.5 ms per code step.
// (R21) Per-axis level flags set on a detected level event.
// (R22) All registers reset to zero and read back; unused bits read zero.
// (R23) Signed Z trim is added to raw Z before reporting or comparing.
`timescale 1ns/1ps
module mdc_regs #(
   parameter int CLK_KHZ = 100000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port from the serial front end
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Raw samples, sample strobe, pulse windows and data ready flag
   input wire logic sample_valid,
   input wire logic [7:0] x_raw,
   input wire logic [7:0] y_raw,
   input wire logic [9:0] z_raw,
   input wire logic [7:0] latency_window,
   input wire logic [7:0] second_window,
   input wire logic data_ready_flag,
   // Corrected Z result
   output logic [9:0] z_corrected,
   // Configuration to the analog and serial sides
   output mdc_pkg::mdc_mode_t op_mode,
   output logic [6:0] sens_lsb_per_g,
   output logic self_test_on,
   output logic three_wire_select,
   output logic filter_bandwidth_select,
   output logic [10:0] filter_bw_dhz,
   output logic output_drive_select,
   output logic [16:0] pulse_duration_us,
   // Detection source and pins
   output logic [7:0] detect_source,
   output logic first_interrupt_pin,
   output logic second_interrupt_pin
);
   import mdc_pkg::*;

   logic [7:0] ztrim_lo_r, ztrim_hi_r, mode_r, clr_r, ctrl1_r, ctrl2_r, lvl_th_r, pls_th_r, pls_dur_r;
   logic [2:0] lvl_flag_r, pls_flag_r;
   logic first_irq_r, second_irq_r;
   logic [2:0] lvl_hit, pls_hit;
   logic lvl_any, pls_any;
   logic first_evt, second_evt;
   logic clr_first, clr_second;
   logic [2:0] axis_dis;
   logic signed [10:0] z_trim;
   logic signed [11:0] z_sum;
   logic [7:0] z_cmp;
   mdc_assign_t asg;
   // Event, clear and next-state terms
   logic lvl_ev, pls_ev, single_ok;
   logic lvl_clr, pls_clr;
   logic [2:0] lvl_flag_nxt, pls_flag_nxt;
   logic first_irq_nxt, second_irq_nxt;
   logic ready_to_pin, first_pin_nxt, second_pin_nxt;

   // Register writes; unused bits masked so they read zero [R22]
   always_ff @(posedge clk) begin
      if (srst) begin
         ztrim_lo_r <= MDC_RESET_VAL;
         ztrim_hi_r <= MDC_RESET_VAL;
         mode_r <= MDC_RESET_VAL;
         clr_r <= MDC_RESET_VAL;
         ctrl1_r <= MDC_RESET_VAL;
         ctrl2_r <= MDC_RESET_VAL;
         lvl_th_r <= MDC_RESET_VAL;
         pls_th_r <= MDC_RESET_VAL;
         pls_dur_r <= MDC_RESET_VAL;
      end else if (reg_wr) begin
         case (reg_addr)
            MDC_ADDR_ZTRIM_LO: ztrim_lo_r <= reg_wdata; // [R01]
            MDC_ADDR_ZTRIM_HI: ztrim_hi_r <= reg_wdata & MDC_MASK_ZTRIM_HI; // [R02]
            MDC_ADDR_MODE: mode_r <= reg_wdata & MDC_MASK_MODE;
            MDC_ADDR_LATCH_CLR: clr_r <= reg_wdata & MDC_MASK_LATCH_CLR;
            MDC_ADDR_CTRL_ONE: ctrl1_r <= reg_wdata;
            MDC_ADDR_CTRL_TWO: ctrl2_r <= reg_wdata & MDC_MASK_CTRL_TWO;
            MDC_ADDR_LVL_TH: lvl_th_r <= reg_wdata; // [R18]
            MDC_ADDR_PLS_TH: pls_th_r <= reg_wdata; // [R19]
            MDC_ADDR_PLS_DUR: pls_dur_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped offsets read zero [R22]
   always_comb begin
      case (reg_addr)
         MDC_ADDR_ZTRIM_LO: reg_rdata = ztrim_lo_r;
         MDC_ADDR_ZTRIM_HI: reg_rdata = ztrim_hi_r;
         MDC_ADDR_MODE: reg_rdata = mode_r;
         MDC_ADDR_LATCH_CLR: reg_rdata = clr_r;
         MDC_ADDR_CTRL_ONE: reg_rdata = ctrl1_r;
         MDC_ADDR_CTRL_TWO: reg_rdata = ctrl2_r;
         MDC_ADDR_LVL_TH: reg_rdata = lvl_th_r;
         MDC_ADDR_PLS_TH: reg_rdata = pls_th_r;
         MDC_ADDR_PLS_DUR: reg_rdata = pls_dur_r;
         default: reg_rdata = 8'h00;
      endcase
   end

   // Mode control decode
   assign op_mode = mdc_mode_t'(mode_r[MDC_MODE_LSB +: 2]); // [R05]
   assign self_test_on = mode_r[MDC_SELF_TEST_BIT]; // [R04]
   assign three_wire_select = mode_r[MDC_THREE_WIRE_BIT]; // [R06]
   always_comb begin
      case (mode_r[MDC_GRANGE_LSB +: 2])
         2'b00: sens_lsb_per_g = MDC_SENS_8G; // [R03]
         2'b01: sens_lsb_per_g = MDC_SENS_2G; // [R03]
         2'b10: sens_lsb_per_g = MDC_SENS_4G; // [R03]
         default: sens_lsb_per_g = MDC_SENS_8G;
      endcase
   end

   // Control decode
   assign filter_bandwidth_select = ctrl1_r[MDC_BW_BIT];
   assign filter_bw_dhz = ctrl1_r[MDC_BW_BIT] ? MDC_BW_HIGH_DHZ : MDC_BW_LOW_DHZ; // [R14]
   assign output_drive_select = ctrl2_r[MDC_DRIVE_BIT]; // [R17]
   // Seventeen bits so the top code still fits in microseconds
   assign pulse_duration_us = 17'(pls_dur_r * MDC_PLS_STEP_US); // [R20]
   assign axis_dis = ctrl1_r[MDC_AXIS_DIS_LSB +: 3];
   assign asg = mdc_assign_t'(ctrl1_r[MDC_ASSIGN_LSB +: 2]);

   // Trim is sign-extended; low bit weighs half an output LSB, so sample is doubled first [R23]
   assign z_trim = {ztrim_hi_r[2:0], ztrim_lo_r};
   assign z_sum = 12'({z_raw[9], z_raw, 1'b0}) + 12'(z_trim);
   assign z_corrected = z_sum[10:1]; // [R23]
   // Comparator uses the 8-bit view of the corrected Z
   assign z_cmp = z_corrected[9:2];

   // Level comparator: option and polarity apply [R13] [R15]
   mdc_axis_cmp #(.AXES(3)) u_level (
      .sample({z_cmp, y_raw, x_raw}),
      .axis_disable(axis_dis), // [R12]
      .threshold(lvl_th_r),
      .signed_mode(ctrl1_r[MDC_TH_OPT_BIT]),
      .neg_polarity(ctrl2_r[MDC_LVL_POL_BIT]),
      .hit(lvl_hit),
      .combined(lvl_any)
   );

   // Pulse comparator ignores the threshold option [R13] [R16]
   mdc_axis_cmp #(.AXES(3)) u_pulse (
      .sample({z_cmp, y_raw, x_raw}),
      .axis_disable(axis_dis), // [R12]
      .threshold({1'b0, pls_th_r[6:0]}),
      .signed_mode(1'b0),
      .neg_polarity(ctrl2_r[MDC_PLS_POL_BIT]),
      .hit(pls_hit),
      .combined(pls_any)
   );

   // Detection only in its own mode, judged per sample
   assign lvl_ev = sample_valid && (op_mode == MDC_MODE_LEVEL) && lvl_any;
   assign pls_ev = sample_valid && (op_mode == MDC_MODE_PULSE) && pls_any;
   // With both windows open only a double pulse may reach the second flag; this bank
   // has no double-pulse timing, so a single pulse is withheld there [R10]
   assign single_ok = (second_window == 8'h00) || (latency_window == 8'h00);

   // Event routing per assignment field
   always_comb begin
      case (asg)
         MDC_ASG_LVL_PLS: begin
            first_evt = lvl_ev; // [R09]
            second_evt = pls_ev;
         end
         MDC_ASG_PLS_LVL: begin
            first_evt = pls_ev; // [R09]
            second_evt = lvl_ev;
         end
         MDC_ASG_SGL_DBL: begin
            first_evt = pls_ev; // [R09]
            second_evt = pls_ev && single_ok; // [R10]
         end
         default: begin
            first_evt = 1'b0;
            second_evt = 1'b0;
         end
      endcase
   end

   // A latch-clear write is a one-cycle action
   assign clr_first = reg_wr && (reg_addr == MDC_ADDR_LATCH_CLR) && reg_wdata[MDC_CLR_FIRST_BIT];
   assign clr_second = reg_wr && (reg_addr == MDC_ADDR_LATCH_CLR) && reg_wdata[MDC_CLR_SECOND_BIT];

   // Next interrupt flags: a new event wins over a clear in the same cycle [R08]
   assign first_irq_nxt = first_evt | (first_irq_r & ~clr_first); // [R08]
   assign second_irq_nxt = second_evt | (second_irq_r & ~clr_second); // [R08]

   // Interrupt flag registers
   always_ff @(posedge clk) begin
      if (srst) begin
         first_irq_r <= 1'b0;
         second_irq_r <= 1'b0;
      end else begin
         first_irq_r <= first_irq_nxt;
         second_irq_r <= second_irq_nxt;
      end
   end

   // Axis-flag clear follows whichever flag owns level or pulse [R08]
   // Without an owner either clear empties them, so no flag sticks until reset
   always_comb begin
      case (asg)
         MDC_ASG_LVL_PLS: begin
            lvl_clr = clr_first;
            pls_clr = clr_second;
         end
         MDC_ASG_PLS_LVL: begin
            lvl_clr = clr_second;
            pls_clr = clr_first;
         end
         default: begin
            lvl_clr = clr_first | clr_second;
            pls_clr = clr_first | clr_second;
         end
      endcase
   end

   // Next axis flags; a new hit wins over a clear in the same cycle [R08]
   always_comb begin
      lvl_flag_nxt = lvl_flag_r;
      pls_flag_nxt = pls_flag_r;
      if (lvl_ev) begin
         lvl_flag_nxt = lvl_flag_r | lvl_hit; // [R21]
      end else if (lvl_clr) begin
         lvl_flag_nxt = 3'h0; // [R08]
      end
      if (pls_ev) begin
         pls_flag_nxt = pls_flag_r | pls_hit;
      end else if (pls_clr) begin
         pls_flag_nxt = 3'h0; // [R08]
      end
   end

   // Axis flag registers
   always_ff @(posedge clk) begin
      if (srst) begin
         lvl_flag_r <= 3'h0;
         pls_flag_r <= 3'h0;
      end else begin
         lvl_flag_r <= lvl_flag_nxt;
         pls_flag_r <= pls_flag_nxt;
      end
   end

   // Source layout: level XYZ, pulse XYZ, second, first
   assign detect_source = {lvl_flag_r[0], lvl_flag_r[1], lvl_flag_r[2],
                           pls_flag_r[0], pls_flag_r[1], pls_flag_r[2], second_irq_r, first_irq_r};

   // Data ready shares the first pin unless disabled [R07]
   assign ready_to_pin = data_ready_flag & ~mode_r[MDC_READY_DIS_BIT];

   // Pin routing by the swap bit [R07] [R11]
   always_comb begin
      if (ctrl1_r[MDC_PIN_SWAP_BIT]) begin
         first_pin_nxt = second_irq_r | ready_to_pin; // [R11]
         second_pin_nxt = first_irq_r; // [R11]
      end else begin
         first_pin_nxt = first_irq_r | ready_to_pin; // [R07]
         second_pin_nxt = second_irq_r;
      end
   end

   // Pins are registered so they never glitch while a flag settles
   always_ff @(posedge clk) begin
      if (srst) begin
         first_interrupt_pin <= 1'b0;
         second_interrupt_pin <= 1'b0;
      end else begin
         first_interrupt_pin <= first_pin_nxt;
         second_interrupt_pin <= second_pin_nxt;
      end
   end
endmodule : mdc_regs

// *** sim/mdc_host_model.sv ***
// Host master model for the byte-wide register port.
// Assumes one-cycle write strobes and combinational read data.
`timescale 1ns/1ps
module mdc_host_model (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // Data is scrambled after the strobe so nothing leans on a stale byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= (a == 8'h1b) ? {1'b0, d[6:0]} : d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~reg_wdata;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : mdc_host_model

// *** sim/mdc_regs_assertions.sv ***
// Port checker for the configuration bank.
// Assumes a bind onto mdc_regs from the bench top.
`timescale 1ns/1ps
module mdc_regs_chk (
   // Clock, reset, register port, sample strobe and data ready
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic data_ready_flag,
   // Outputs under watch
   input wire mdc_pkg::mdc_mode_t op_mode,
   input wire logic [6:0] sens_lsb_per_g,
   input wire logic self_test_on,
   input wire logic filter_bandwidth_select,
   input wire logic [10:0] filter_bw_dhz,
   input wire logic [16:0] pulse_duration_us,
   input wire logic [7:0] detect_source,
   input wire logic first_interrupt_pin,
   input wire logic second_interrupt_pin
);
   import mdc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Mode write lands one cycle later
   property p_mode;
      reg_wr && reg_addr == MDC_ADDR_MODE |=> op_mode == $past(reg_wdata[1:0]) && self_test_on == $past(reg_wdata[4]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode field not applied");
   property p_range;
      reg_addr == MDC_ADDR_MODE && reg_rdata[3:2] != 2'b11 |->
         sens_lsb_per_g == (reg_rdata[3] ? MDC_SENS_4G : reg_rdata[2] ? MDC_SENS_2G : MDC_SENS_8G);
   endproperty
   a_range: assert property (p_range) else $error("sensitivity mismatch");
   property p_bw;
      reg_addr == MDC_ADDR_CTRL_ONE |-> filter_bandwidth_select == reg_rdata[7] &&
         filter_bw_dhz == (reg_rdata[7] ? MDC_BW_HIGH_DHZ : MDC_BW_LOW_DHZ);
   endproperty
   a_bw: assert property (p_bw) else $error("bandwidth mismatch");
   // Every code is judged, the top one included
   property p_dur;
      reg_addr == MDC_ADDR_PLS_DUR |-> 32'(pulse_duration_us) == 32'(reg_rdata) * 500;
   endproperty
   a_dur: assert property (p_dur) else $error("pulse duration mismatch");
   property p_unused;
      reg_addr == MDC_ADDR_ZTRIM_HI |-> reg_rdata[7:3] == 5'h00;
   endproperty
   a_unused: assert property (p_unused) else $error("unused trim bits read back");
   property p_clear;
      reg_wr && reg_addr == MDC_ADDR_LATCH_CLR && reg_wdata[1:0] == 2'b11 && !sample_valid |=> detect_source[1:0] == 2'b00;
   endproperty
   a_clear: assert property (p_clear) else $error("latch clear ignored");
   property p_level;
      $rose(detect_source[7]) |-> $past(sample_valid);
   endproperty
   a_level: assert property (p_level) else $error("level flag without sample");
   property p_pins;
      detect_source[1:0] == 2'b00 && !data_ready_flag |=> !first_interrupt_pin && !second_interrupt_pin;
   endproperty
   a_pins: assert property (p_pins) else $error("pin high without flag");
   c_level: cover property ($rose(detect_source[7]));
   c_pin: cover property ($rose(second_interrupt_pin));
   c_clear: cover property (reg_wr && reg_addr == MDC_ADDR_LATCH_CLR);
endmodule : mdc_regs_chk

// *** sim/motion_detect_config_regs_test.sv ***
// Self-checking bench for the configuration bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module motion_detect_config_regs_test;
   import mdc_pkg::*;
   logic clk, srst, reg_wr, sample_valid, data_ready_flag, st, tw, bws, drv, pin1, pin2;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, x_raw, y_raw, lat_w, sec_w, src, rb;
   logic [9:0] z_raw, z_corr;
   logic [6:0] sens;
   logic [10:0] bw;
   logic [16:0] dur;
   mdc_mode_t op_mode;
   int mismatches, n_compared, cyc;
   logic [7:0] masks [9] = '{8'hff, 8'h07, 8'h7f, 8'h03, 8'hff, 8'h07, 8'hff, 8'h7f, 8'hff};
   logic [7:0] pexp [4] = '{8'h12, 8'h11, 8'h13, 8'h11};
   mdc_host_model i_host(.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   mdc_regs i_dut(.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid), .x_raw(x_raw), .y_raw(y_raw), .z_raw(z_raw),
      .latency_window(lat_w), .second_window(sec_w), .data_ready_flag(data_ready_flag), .z_corrected(z_corr),
      .op_mode(op_mode), .sens_lsb_per_g(sens), .self_test_on(st), .three_wire_select(tw),
      .filter_bandwidth_select(bws), .filter_bw_dhz(bw), .output_drive_select(drv), .pulse_duration_us(dur),
      .detect_source(src), .first_interrupt_pin(pin1), .second_interrupt_pin(pin2));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, far above the fewer than two hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic test_done();
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, rb);
      chk("reg_rdata", e, rb);
   endtask : rc
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
   endtask : do_reset
   // One sample cycle; returns where the flags have just landed
   task automatic smp(input logic [7:0] x);
      @(posedge clk);
      sample_valid <= 1'b1;
      x_raw <= x;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(negedge clk);
   endtask : smp
   initial begin
      srst = 1'b1;
      {sample_valid, data_ready_flag} = 2'b00;
      {x_raw, y_raw, lat_w, sec_w} = '0;
      z_raw = 10'h000;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 9; i++) rc(8'h14 + 8'(i), 8'h00);
      for (int i = 0; i < 9; i++) begin
         i_host.wr(8'h14 + 8'(i), 8'hff);
         rc(8'h14 + 8'(i), masks[i]);
      end
      i_host.wr(8'h1d, 8'h5a);
      rc(8'h1d, 8'h00);
      chk("cfg_bits", 4'hf, {st, tw, bws, drv});
      chk("filter_bw_dhz", 1250, bw);
      do_reset();
      @(negedge clk);
      chk("cfg_bits", 4'h0, {st, tw, bws, drv});
      chk("filter_bw_dhz", 625, bw);
      // Mode i with range i in one byte
      for (int i = 0; i < 4; i++) begin
         i_host.wr(MDC_ADDR_MODE, 8'(i * 5));
         @(negedge clk);
         chk("op_mode", i, op_mode);
         chk("sens", i == 1 ? 64 : i == 2 ? 32 : 16, sens);
      end
      i_host.wr(MDC_ADDR_PLS_DUR, 8'h01);
      rc(MDC_ADDR_PLS_DUR, 8'h01);
      chk("pulse_duration_us", 500, dur);
      i_host.wr(MDC_ADDR_PLS_DUR, 8'hff);
      rc(MDC_ADDR_PLS_DUR, 8'hff);
      chk("pulse_duration_us", 127500, dur);
      // Trim of -2 half steps, then bit 8 alone
      z_raw <= 10'd100;
      i_host.wr(MDC_ADDR_ZTRIM_LO, 8'hfe);
      i_host.wr(MDC_ADDR_ZTRIM_HI, 8'h07);
      @(negedge clk);
      chk("z_corrected", 99, z_corr);
      i_host.wr(MDC_ADDR_ZTRIM_LO, 8'h00);
      i_host.wr(MDC_ADDR_ZTRIM_HI, 8'h01);
      @(negedge clk);
      chk("z_corrected", 228, z_corr);
      do_reset();
      z_raw <= 10'h000;
      i_host.wr(MDC_ADDR_LVL_TH, 8'h20);
      i_host.wr(MDC_ADDR_MODE, 8'h02);
      smp(8'h30);
      chk("detect_source", 8'h81, src);
      @(negedge clk);
      chk("pins", 2'b10, {pin1, pin2});
      i_host.wr(MDC_ADDR_LATCH_CLR, 8'h01);
      @(negedge clk);
      chk("detect_source", 8'h00, src);
      i_host.wr(MDC_ADDR_CTRL_ONE, 8'h03);
      smp(8'h30);
      chk("detect_source", 8'h82, src);
      @(negedge clk);
      chk("pins", 2'b10, {pin1, pin2});
      i_host.wr(MDC_ADDR_LATCH_CLR, 8'h02);
      i_host.wr(MDC_ADDR_CTRL_ONE, 8'h08);
      smp(8'h30);
      chk("detect_source", 8'h00, src);
      i_host.wr(MDC_ADDR_CTRL_TWO, 8'h01);
      smp(8'h30);
      chk("detect_source", 8'h61, src);
      do_reset();
      i_host.wr(MDC_ADDR_LVL_TH, 8'h20);
      i_host.wr(MDC_ADDR_CTRL_ONE, 8'h40);
      i_host.wr(MDC_ADDR_MODE, 8'h02);
      smp(8'hd0);
      chk("detect_source", 8'h00, src);
      // Pulse routing per assignment; last pass opens both windows
      for (int i = 0; i < 4; i++) begin
         do_reset();
         lat_w <= 8'h05;
         sec_w <= (i == 3) ? 8'h05 : 8'h00;
         i_host.wr(MDC_ADDR_PLS_TH, 8'h20);
         i_host.wr(MDC_ADDR_CTRL_ONE, 8'(i == 3 ? 4 : i * 2));
         i_host.wr(MDC_ADDR_MODE, 8'h03);
         smp(8'h30);
         chk("detect_source", pexp[i], src);
      end
      // Negative pulse polarity: every axis below threshold sets all pulse flags
      i_host.wr(MDC_ADDR_CTRL_TWO, 8'h02);
      smp(8'h10);
      chk("detect_source", 8'h1d, src);
      do_reset();
      data_ready_flag <= 1'b1;
      repeat (2) @(negedge clk);
      chk("first_interrupt_pin", 1, pin1);
      i_host.wr(MDC_ADDR_MODE, 8'h40);
      repeat (2) @(negedge clk);
      chk("first_interrupt_pin", 0, pin1);
      test_done();
   end
endmodule : motion_detect_config_regs_test
bind mdc_regs mdc_regs_chk i_chk(.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .data_ready_flag(data_ready_flag),
   .op_mode(op_mode), .sens_lsb_per_g(sens_lsb_per_g), .self_test_on(self_test_on),
   .filter_bandwidth_select(filter_bandwidth_select), .filter_bw_dhz(filter_bw_dhz),
   .pulse_duration_us(pulse_duration_us), .detect_source(detect_source),
   .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin));
